// *** hw/mbts_cfg.svh ***
/*
 * Constants of the request server: header layout, function and exception
 * codes, quantity limits and idle timing.
 * Assumes inclusion by the server module file only.
 */
// Functional notes
// - Seven header bytes precede the function code
// - Transaction identifier copied into the response
// - Protocol identifier zero; length counts following bytes
// - Header ends with unit identifier byte
// - Function code is one byte; 128-255 exceptions
// - Accept codes 01-04, 05, 0F, 10
// - Unsupported function code gives exception response
// - Excess quantity or bad address gives exception
// - Normal response echoes the function code
// - Exception response sets function code MSB
// - Exception response data holds exception code
// - Normal response data holds requested data
// - Multi-byte quantities sent high byte first
// - Bit items packed one bit per item
// - Register reads return 16-bit words, high first
// - Zero-length data field is accepted
// - Server only answers, never transmits unsolicited
// - Idle connection closed after 60 s if enabled
`ifndef MBTS_CFG_SVH
`define MBTS_CFG_SVH

`define MBTS_HDR_LEN     4'd7
`define MBTS_FC_RD_COIL  8'h01
`define MBTS_FC_RD_DISC  8'h02
`define MBTS_FC_RD_HOLD  8'h03
`define MBTS_FC_RD_INP   8'h04
`define MBTS_FC_WR_COIL  8'h05
`define MBTS_FC_WR_COILS 8'h0f
`define MBTS_FC_WR_REGS  8'h10
`define MBTS_EXC_FLAG    8'h80
`define MBTS_EX_FUNC     8'h01
`define MBTS_EX_ADDR     8'h02
`define MBTS_EX_VALUE    8'h03
`define MBTS_COIL_ON     16'hff00
`define MBTS_COIL_OFF    16'h0000
`define MBTS_MAX_RD_BITS 16'h07d0
`define MBTS_MAX_RD_REGS 16'h007d
`define MBTS_MAX_WR_BITS 16'h07b0
`define MBTS_MAX_WR_REGS 16'h007b
`define MBTS_IDLE_SEC    64'd60
`define MBTS_CLK_HZ      64'd50000000

`endif

// *** hw/mbts_pkg.sv ***
/*
 * Types of the request server.
 * Assumes nothing beyond the compile order.
 */
package mbts_pkg;

    // ************************************************************
    // Sequencer states
    // ************************************************************
    typedef enum logic [2:0] {
        ST_HDR,
        ST_BODY,
        ST_EXEC,
        ST_HEAD,
        ST_BITS,
        ST_RD,
        ST_HI,
        ST_LO
    } mbts_state_t;

endpackage

// *** hw/mbts_word_mem.sv ***
/*
 * Word memory with one write port and a registered read port.
 * Assumes a single clock and synchronous active-low reset.
 */
`timescale 1ns/1ps
module mbts_word_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input  logic                     clk,
    input  logic                     rst_n,
    input  logic                     wrEn,
    input  logic [$clog2(DEPTH)-1:0] wrAddr,
    input  logic [WIDTH-1:0]         wrData,
    input  logic [$clog2(DEPTH)-1:0] rdAddr,
    output logic [WIDTH-1:0]         rdData
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdData <= '0;
        end else begin
            rdData <= mem[rdAddr];
        end
    end
endmodule

// *** hw/mbts_fifo.sv ***
/*
 * Byte FIFO with a registered output stage.
 * Assumes a single clock and synchronous active-low reset.
 */
`timescale 1ns/1ps
module mbts_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  logic             clk,
    input  logic             rst_n,
    input  logic [WIDTH-1:0] inData,
    input  logic             inValid,
    output logic             inReady,
    output logic [WIDTH-1:0] outData,
    output logic             outValid,
    input  logic             outReady
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    rp_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             load;

    assign inReady = cnt_r < (AW+1)'(DEPTH);
    assign push    = inValid && inReady;
    assign load    = (cnt_r != '0) && (!outValid || outReady);

    // ************************************************************
    // Storage
    // ************************************************************
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_r] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= push ? wp_r + 1'b1 : wp_r;
            rp_r  <= load ? rp_r + 1'b1 : rp_r;
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(load);
        end
    end

    // ************************************************************
    // Output stage
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            outData  <= '0;
            outValid <= 1'b0;
        end else if (load) begin
            outData  <= mem[rp_r];
            outValid <= 1'b1;
        end else if (outReady) begin
            outValid <= 1'b0;
        end
    end
endmodule

// *** hw/mbts_server.sv ***
/*
 * Request server: parses header and function code from the request byte
 * stream, executes reads and writes, queues the response in a FIFO.
 * Assumes a byte stream from the TCP layer on the same clock, one request
 * at a time, and discrete and register inputs on the same clock.
 */
`timescale 1ns/1ps
`include "mbts_cfg.svh"
module mbts_server
    import mbts_pkg::*;
#(
    parameter int          COIL_N      = 32,
    parameter int          DI_N        = 16,
    parameter int          HR_N        = 32,
    parameter int          AI_N        = 16,
    parameter logic [31:0] IDLE_CYCLES = 32'(`MBTS_IDLE_SEC * `MBTS_CLK_HZ)
) (
    input  logic              clk,
    input  logic              rst_n,
    input  logic [7:0]        unitId,
    input  logic [7:0]        rxData,
    input  logic              rxValid,
    output logic              rxReady,
    output logic [7:0]        txData,
    output logic              txValid,
    input  logic              txReady,
    input  logic              connOpen,
    input  logic              autoDiscEn,
    input  logic [DI_N-1:0]   discIn,
    input  logic [16*AI_N-1:0] inRegs,
    output logic [COIL_N-1:0] coilOut,
    output logic              closeConn
);
    localparam int HA = $clog2(HR_N);

    mbts_state_t state_r;
    mbts_state_t state_nxt;
    logic [2:0]  idx_r;
    logic [15:0] tid_r;
    logic [15:0] pid_r;
    logic [15:0] len_r;
    logic [7:0]  uid_r;
    logic [7:0]  fc_r;
    logic [15:0] addr_r;
    logic [15:0] qty_r;
    logic [7:0]  bc_r;
    logic [15:0] pos_r;
    logic [15:0] remain_r;
    logic [7:0]  wrHi_r;
    logic [7:0]  errCode_r;
    logic        discard_r;
    logic [3:0]  tIdx_r;
    logic [15:0] kIdx_r;
    logic [15:0] aiWord_r;
    logic [31:0] idleCnt_r;
    logic        rxAcc;
    logic        push;
    logic        fifoInReady;
    logic        fifoValid;
    logic [7:0]  fifoData;
    logic [15:0] lenRemain;
    logic [7:0]  errHead;
    logic [15:0] dataPos;
    logic        isBits;
    logic        isRegs;
    logic [7:0]  bcOut;
    logic [15:0] rspLen;
    logic [3:0]  headLen;
    logic [7:0]  headByte;
    logic [7:0]  bitsByte;
    logic [15:0] hrRdData;
    logic        hrWrEn;

    // Quantity checked before address, value error first
    function automatic logic [7:0] rangeErr(input logic [15:0] qty, input logic [15:0] qmax,
                                            input logic [15:0] addr, input int size);
        logic [16:0] lastEnd;
        lastEnd = {1'b0, addr} + {1'b0, qty};
        if (qty == 16'h0000 || qty > qmax) begin
            return `MBTS_EX_VALUE;
        end else if (lastEnd > 17'(size)) begin
            return `MBTS_EX_ADDR;
        end
        return 8'h00;
    endfunction

    assign rxAcc     = rxValid && rxReady;
    assign lenRemain = (len_r >= 16'h0002) ? len_r - 16'h0002 : 16'h0000;
    assign dataPos   = pos_r - 16'h0005;
    assign isBits    = fc_r == `MBTS_FC_RD_COIL || fc_r == `MBTS_FC_RD_DISC;
    assign isRegs    = fc_r == `MBTS_FC_RD_HOLD || fc_r == `MBTS_FC_RD_INP;

    // ************************************************************
    // Request checks
    // ************************************************************
    always_comb begin
        errHead = 8'h00;
        unique case (fc_r)
            `MBTS_FC_RD_COIL:  errHead = rangeErr(qty_r, `MBTS_MAX_RD_BITS, addr_r, COIL_N);
            `MBTS_FC_RD_DISC:  errHead = rangeErr(qty_r, `MBTS_MAX_RD_BITS, addr_r, DI_N);
            `MBTS_FC_RD_HOLD:  errHead = rangeErr(qty_r, `MBTS_MAX_RD_REGS, addr_r, HR_N);
            `MBTS_FC_RD_INP:   errHead = rangeErr(qty_r, `MBTS_MAX_RD_REGS, addr_r, AI_N);
            `MBTS_FC_WR_COIL: begin
                if (qty_r != `MBTS_COIL_ON && qty_r != `MBTS_COIL_OFF) begin
                    errHead = `MBTS_EX_VALUE;
                end else begin
                    errHead = rangeErr(16'h0001, 16'h0001, addr_r, COIL_N);
                end
            end
            `MBTS_FC_WR_COILS: begin
                errHead = rangeErr(qty_r, `MBTS_MAX_WR_BITS, addr_r, COIL_N);
                if (16'(bc_r) != (qty_r + 16'h0007) >> 3) begin
                    errHead = `MBTS_EX_VALUE;
                end
            end
            `MBTS_FC_WR_REGS: begin
                errHead = rangeErr(qty_r, `MBTS_MAX_WR_REGS, addr_r, HR_N);
                if (16'(bc_r) != {qty_r[14:0], 1'b0}) begin
                    errHead = `MBTS_EX_VALUE;
                end
            end
            default:           errHead = `MBTS_EX_FUNC;
        endcase
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_HDR: begin
                // no data field goes straight to execution
                if (rxAcc && idx_r == 3'd7) begin
                    state_nxt = (lenRemain == 16'h0000) ? ST_EXEC : ST_BODY;
                end
            end
            ST_BODY: begin
                if (rxAcc && remain_r == 16'h0001) begin
                    state_nxt = ST_EXEC;
                end
            end
            // answer only after a whole request
            ST_EXEC: state_nxt = discard_r ? ST_HDR : ST_HEAD;
            ST_HEAD: begin
                if (push && tIdx_r == headLen - 4'd1) begin
                    if (errCode_r != 8'h00) begin
                        state_nxt = ST_HDR;
                    end else if (isBits) begin
                        state_nxt = ST_BITS;
                    end else if (isRegs) begin
                        state_nxt = ST_RD;
                    end else begin
                        state_nxt = ST_HDR;
                    end
                end
            end
            ST_BITS: begin
                if (push && kIdx_r == 16'(bcOut) - 16'h0001) begin
                    state_nxt = ST_HDR;
                end
            end
            ST_RD: state_nxt = ST_HI;
            ST_HI: state_nxt = push ? ST_LO : ST_HI;
            ST_LO: begin
                if (push) begin
                    state_nxt = (kIdx_r == qty_r - 16'h0001) ? ST_HDR : ST_RD;
                end
            end
        endcase
    end

    // one byte per handshake, in order
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= ST_HDR;
            rxReady <= 1'b0;
        end else begin
            state_r <= state_nxt;
            rxReady <= state_nxt == ST_HDR || state_nxt == ST_BODY;
        end
    end

    // ************************************************************
    // Header capture
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            idx_r     <= 3'd0;
            tid_r     <= 16'h0000;
            pid_r     <= 16'h0000;
            len_r     <= 16'h0000;
            uid_r     <= 8'h00;
            fc_r      <= 8'h00;
            discard_r <= 1'b0;
        end else if (state_r == ST_HDR && rxAcc) begin
            // seven header bytes, then function code
            idx_r <= idx_r + 3'd1;
            unique case (idx_r)
                3'd0: tid_r[15:8] <= rxData;
                3'd1: tid_r[7:0]  <= rxData;
                3'd2: pid_r[15:8] <= rxData;
                3'd3: pid_r[7:0]  <= rxData;
                3'd4: len_r[15:8] <= rxData;
                3'd5: len_r[7:0]  <= rxData;
                3'd6: begin
                    uid_r     <= rxData;
                    discard_r <= pid_r != 16'h0000 || rxData != unitId;
                end
                3'd7: fc_r <= rxData;
            endcase
        end
    end

    // ************************************************************
    // Data field capture
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            addr_r    <= 16'h0000;
            qty_r     <= 16'h0000;
            bc_r      <= 8'h00;
            pos_r     <= 16'h0000;
            remain_r  <= 16'h0000;
            wrHi_r    <= 8'h00;
            errCode_r <= 8'h00;
        end else if (state_r == ST_HDR && rxAcc && idx_r == 3'd7) begin
            // length covers unit id and function code
            remain_r <= lenRemain;
            pos_r    <= 16'h0000;
            addr_r   <= 16'h0000;
            qty_r    <= 16'h0000;
            bc_r     <= 8'h00;
        end else if (state_r == ST_BODY && rxAcc) begin
            pos_r    <= pos_r + 16'h0001;
            remain_r <= remain_r - 16'h0001;
            unique case (pos_r)
                16'h0000: addr_r[15:8] <= rxData;
                16'h0001: addr_r[7:0]  <= rxData;
                16'h0002: qty_r[15:8]  <= rxData;
                16'h0003: qty_r[7:0]   <= rxData;
                16'h0004: bc_r         <= rxData;
                default:  wrHi_r       <= rxData;
            endcase
        end else if (state_r == ST_EXEC) begin
            if (errHead != 8'h00 || fc_r == `MBTS_FC_RD_COIL || fc_r == `MBTS_FC_RD_DISC
                || isRegs || fc_r == `MBTS_FC_WR_COIL) begin
                errCode_r <= (errHead == 8'h00 && pos_r < 16'h0004) ? `MBTS_EX_VALUE : errHead;
            end else begin
                errCode_r <= (pos_r < 16'h0005 + 16'(bc_r)) ? `MBTS_EX_VALUE : 8'h00;
            end
        end
    end

    // ************************************************************
    // Coils and holding registers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            coilOut <= '0;
        end else if (state_r == ST_BODY && rxAcc && fc_r == `MBTS_FC_WR_COILS && !discard_r
                     && errHead == 8'h00 && pos_r >= 16'h0005) begin
            for (int j = 0; j < 8; j++) begin
                if ({dataPos[12:0], 3'(j)} < qty_r
                    && int'(addr_r) + int'({dataPos[12:0], 3'(j)}) < COIL_N) begin
                    coilOut[int'(addr_r) + int'({dataPos[12:0], 3'(j)})] <= rxData[j];
                end
            end
        end else if (state_r == ST_EXEC && fc_r == `MBTS_FC_WR_COIL && !discard_r
                     && errHead == 8'h00 && pos_r >= 16'h0004) begin
            coilOut[HA'(0) + int'(addr_r[$clog2(COIL_N)-1:0])] <= qty_r == `MBTS_COIL_ON;
        end
    end

    // register data pairs high byte first
    assign hrWrEn = state_r == ST_BODY && rxAcc && fc_r == `MBTS_FC_WR_REGS && !discard_r
                    && errHead == 8'h00 && pos_r >= 16'h0005 && dataPos[0];

    mbts_word_mem #(
        .WIDTH (16),
        .DEPTH (HR_N)
    ) uHoldRegs (
        .clk    (clk),
        .rst_n  (rst_n),
        .wrEn   (hrWrEn),
        .wrAddr (HA'(addr_r + (dataPos >> 1))),
        .wrData ({wrHi_r, rxData}),
        .rdAddr (HA'(addr_r + kIdx_r)),
        .rdData (hrRdData)
    );

    // ************************************************************
    // Response build
    // ************************************************************
    assign bcOut   = isBits ? 8'((qty_r + 16'h0007) >> 3) : 8'({qty_r[14:0], 1'b0});
    assign rspLen  = (errCode_r != 8'h00) ? 16'h0003
                   : (isBits || isRegs) ? 16'h0003 + 16'(bcOut) : 16'h0006;
    assign headLen = (errCode_r != 8'h00 || isBits || isRegs) ? 4'd9 : 4'd12;

    always_comb begin
        headByte = 8'h00;
        unique case (tIdx_r)
            4'd0:    headByte = tid_r[15:8];
            4'd1:    headByte = tid_r[7:0];
            // protocol id zero, length of rest
            4'd2:    headByte = 8'h00;
            4'd3:    headByte = 8'h00;
            4'd4:    headByte = rspLen[15:8];
            4'd5:    headByte = rspLen[7:0];
            4'd6:    headByte = uid_r;
            4'd7:    headByte = (errCode_r != 8'h00) ? (fc_r | `MBTS_EXC_FLAG) : fc_r;
            4'd8:    headByte = (errCode_r != 8'h00) ? errCode_r
                              : (isBits || isRegs) ? bcOut : addr_r[15:8];
            4'd9:    headByte = addr_r[7:0];
            4'd10:   headByte = qty_r[15:8];
            4'd11:   headByte = qty_r[7:0];
            default: headByte = 8'h00;
        endcase
    end

    // one bit per item, unused bits zero
    always_comb begin
        bitsByte = 8'h00;
        for (int j = 0; j < 8; j++) begin
            if ({kIdx_r[12:0], 3'(j)} < qty_r) begin
                if (fc_r == `MBTS_FC_RD_COIL) begin
                    bitsByte[j] = (int'(addr_r) + int'({kIdx_r[12:0], 3'(j)}) < COIL_N)
                                  && coilOut[int'(addr_r) + int'({kIdx_r[12:0], 3'(j)})];
                end else begin
                    bitsByte[j] = (int'(addr_r) + int'({kIdx_r[12:0], 3'(j)}) < DI_N)
                                  && discIn[int'(addr_r) + int'({kIdx_r[12:0], 3'(j)})];
                end
            end
        end
    end

    // requested data follows the byte count
    // each register high byte then low
    always_comb begin
        fifoValid = 1'b1;
        unique case (state_r)
            ST_HEAD: fifoData = headByte;
            ST_BITS: fifoData = bitsByte;
            ST_HI:   fifoData = isRegs && fc_r == `MBTS_FC_RD_HOLD ? hrRdData[15:8]
                              : aiWord_r[15:8];
            ST_LO:   fifoData = fc_r == `MBTS_FC_RD_HOLD ? hrRdData[7:0] : aiWord_r[7:0];
            default: begin
                fifoData  = 8'h00;
                fifoValid = 1'b0;
            end
        endcase
    end
    assign push = fifoValid && fifoInReady;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tIdx_r   <= 4'd0;
            kIdx_r   <= 16'h0000;
            aiWord_r <= 16'h0000;
        end else begin
            if (state_r == ST_EXEC) begin
                tIdx_r <= 4'd0;
                kIdx_r <= 16'h0000;
            end else if (state_r == ST_HEAD && push) begin
                tIdx_r <= tIdx_r + 4'd1;
            end else if ((state_r == ST_BITS || state_r == ST_LO) && push) begin
                kIdx_r <= kIdx_r + 16'h0001;
            end
            if (state_r == ST_RD) begin
                aiWord_r <= (int'(addr_r) + int'(kIdx_r) < AI_N)
                            ? inRegs[16*(int'(addr_r) + int'(kIdx_r)) +: 16] : 16'h0000;
            end
        end
    end

    mbts_fifo #(
        .WIDTH (8),
        .DEPTH (16)
    ) uTxFifo (
        .clk      (clk),
        .rst_n    (rst_n),
        .inData   (fifoData),
        .inValid  (fifoValid),
        .inReady  (fifoInReady),
        .outData  (txData),
        .outValid (txValid),
        .outReady (txReady)
    );

    // ************************************************************
    // Idle disconnect
    // ************************************************************
    // close after idle time when enabled
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            idleCnt_r <= 32'h00000000;
            closeConn <= 1'b0;
        end else if (!connOpen || !autoDiscEn || rxAcc || (txValid && txReady)) begin
            idleCnt_r <= 32'h00000000;
            closeConn <= 1'b0;
        end else if (idleCnt_r >= IDLE_CYCLES - 32'h00000001) begin
            idleCnt_r <= 32'h00000000;
            closeConn <= 1'b1;
        end else begin
            idleCnt_r <= idleCnt_r + 32'h00000001;
            closeConn <= 1'b0;
        end
    end
endmodule

// *** verification/mbts_server_sva.sv ***
/* Port checker of the request server.
   Assumes a bind onto mbts_server. */
`timescale 1ns/1ps
module mbts_server_sva (
    input logic       clk,
    input logic       rst_n,
    input logic       rxValid,
    input logic       rxReady,
    input logic [7:0] txData,
    input logic       txValid,
    input logic       txReady,
    input logic       connOpen,
    input logic       autoDiscEn,
    input logic       closeConn
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_hold; txValid && !txReady |=> txValid && $stable(txData); endproperty
    a_hold: assert property (p_hold) else $error("tx byte lost");
    property p_ans; $fell(rxReady) |-> ##[1:4] (txValid || rxReady); endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_busy; $rose(txValid) |-> !$past(rxReady, 2); endproperty
    a_busy: assert property (p_busy) else $error("tx unsolicited");
    property p_rst; $rose(rst_n) |-> !txValid && !closeConn; endproperty
    a_rst: assert property (p_rst) else $error("output at start");
    property p_pulse; closeConn |=> !closeConn; endproperty
    a_pulse: assert property (p_pulse) else $error("close too long");
    property p_en; closeConn |-> $past(autoDiscEn); endproperty
    a_en: assert property (p_en) else $error("close disabled");
    property p_off; !connOpen |-> ##2 !closeConn; endproperty
    a_off: assert property (p_off) else $error("close no link");
    property p_quiet; rxValid && rxReady |-> ##2 !closeConn [*8]; endproperty
    a_quiet: assert property (p_quiet) else $error("close busy");
endmodule
bind mbts_server mbts_server_sva sva_inst (.clk, .rst_n, .rxValid, .rxReady, .txData,
    .txValid, .txReady, .connOpen, .autoDiscEn, .closeConn);

// *** verification/mbts_client.sv ***
/* Client model: sends queued request bytes, collects response bytes.
   Assumes the bench fills reqQ and reads rspQ. */
`timescale 1ns/1ps
module mbts_client (
    input  logic       clk,
    input  logic       slow,
    output logic [7:0] rxData = 8'h00,
    output logic       rxValid = 1'b0,
    input  logic       rxReady,
    input  logic [7:0] txData,
    input  logic       txValid,
    output logic       txReady = 1'b1
);
    logic [7:0] reqQ[$], rspQ[$];
    always @(posedge clk) begin
        if (rxValid && rxReady) void'(reqQ.pop_front());
        if (txValid && txReady) rspQ.push_back(txData);
    end
    always @(negedge clk) begin
        rxValid <= reqQ.size() != 0;
        rxData <= reqQ.size() != 0 ? reqQ[0] : ~rxData;
        txReady <= !slow || !txReady;
    end
endmodule

// *** verification/mbts_server_bench.sv ***
/* Bench of the request server against the client model.
   Assumes unit id 01 and a 50-cycle idle limit. */
`timescale 1ns/1ps
module mbts_server_bench;
    logic         clk = 1'b0, rst_n = 1'b0, slow = 1'b0, connOpen = 1'b0;
    logic         autoDiscEn = 1'b0, rxValid, rxReady, txValid, txReady, closeConn;
    logic [7:0]   rxData, txData, tid = 8'h10, unitId = 8'h01;
    logic [15:0]  discIn = 16'haa55;
    logic [255:0] inRegs = 256'h5678_1234;
    logic [31:0]  coilOut;
    logic [7:0]   ed[$], ex[$];
    int           failures = 0, totalChecks = 0;
    mbts_server #(.IDLE_CYCLES(32'd50)) mbts_server_inst (.clk, .rst_n, .unitId, .rxData,
        .rxValid, .rxReady, .txData, .txValid, .txReady, .connOpen, .autoDiscEn, .discIn,
        .inRegs, .coilOut, .closeConn);
    mbts_client mbts_client_inst (.clk, .slow, .rxData, .rxValid, .rxReady, .txData,
        .txValid, .txReady);
    initial forever #10 clk = ~clk;
    task automatic cmp8(input logic [7:0] got, exp);
        totalChecks++;
        if (got !== exp) failures++;
        if (got !== exp) $display("ERROR %0t: got %h want %h", $time, got, exp);
    endtask
    task automatic stopTest();
        $display("checks %0d errors %0d", totalChecks, failures);
        if (failures == 0 && totalChecks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic run(input logic [7:0] fc, input logic [31:0] ab);
        logic [7:0] q[$], e[$];
        int         n;
        tid++;
        e = {~tid, tid, 8'h00, 8'h00, 8'h00, 8'(ed.size() + 2), unitId,
            ed.size() == 1 ? fc | 8'h80 : fc, ed};
        q = {~tid, tid, 8'h00, 8'h00, 8'h00, 8'(ab ? 6 + ex.size() : 2), unitId, fc,
            ab[31:24], ab[23:16], ab[15:8], ab[7:0], ex};
        if (!ab) q = q[0:7];
        mbts_client_inst.rspQ = {};
        mbts_client_inst.reqQ = q;
        for (n = 0; n < 400 && mbts_client_inst.rspQ.size() < e.size(); n++) @(negedge clk);
        repeat (8) @(negedge clk);
        cmp8(8'(mbts_client_inst.rspQ.size()), 8'(e.size()));
        if (n == 400) stopTest();
        foreach (e[i]) cmp8(mbts_client_inst.rspQ[i], e[i]);
        ex = {};
    endtask
    task automatic sRead();
        slow = 1'b1;
        ed = '{8'h04, 8'h12, 8'h34, 8'h56, 8'h78};
        run(8'h04, 32'h0000_0002);
        slow = 1'b0;
        ed = '{8'h02, 8'ha5, 8'h02};
        run(8'h02, 32'h0004_000a);
    endtask
    task automatic sDrop();
        mbts_client_inst.rspQ = {};
        mbts_client_inst.reqQ = {8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h06, 8'h02, 8'h03,
            8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h02, 8'h00, 8'h01, 8'h00, 8'h06, unitId,
            8'h03, 8'h00, 8'h00, 8'h00, 8'h01};
        repeat (80) @(negedge clk);
        cmp8(8'(mbts_client_inst.reqQ.size()), 8'h00);
        cmp8(8'(mbts_client_inst.rspQ.size()), 8'h00);
    endtask
    task automatic sErr();
        ed = '{8'h01};
        run(8'h2b, 32'h0);
        run(8'h81, 32'h0);
        ed = '{8'h02};
        run(8'h03, 32'h0020_0001);
        ed = '{8'h03};
        run(8'h03, 32'h0000_007e);
    endtask
    task automatic sWrite();
        ed = '{8'h00, 8'h03, 8'hff, 8'h00};
        run(8'h05, 32'h0003_ff00);
        ex = '{8'h01, 8'ha5};
        ed = '{8'h00, 8'h08, 8'h00, 8'h08};
        run(8'h0f, 32'h0008_0008);
        cmp8(coilOut[15:8], 8'ha5);
        ed = '{8'h02, 8'h08, 8'ha5};
        run(8'h01, 32'h0000_0010);
        ex = '{8'h02, 8'hbe, 8'hef};
        ed = '{8'h00, 8'h02, 8'h00, 8'h01};
        run(8'h10, 32'h0002_0001);
        ed = '{8'h02, 8'hbe, 8'hef};
        run(8'h03, 32'h0002_0001);
    endtask
    task automatic sIdle();
        int n;
        connOpen = 1'b1;
        autoDiscEn = 1'b1;
        for (n = 0; n < 200 && closeConn !== 1'b1; n++) @(negedge clk);
        cmp8(8'(n), 8'd50);
    endtask
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        sRead();
        sDrop();
        sErr();
        sWrite();
        sIdle();
        stopTest();
    end
endmodule
